// ---- hdl/cmr_pkg.sv ----
// Package of constants for the clock mode and reset watchdog block
package cmr_pkg;
    // Register port geometry
    localparam int AW = 8;
    localparam int DW = 8;
    // Register addresses
    localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAG = 8'h01;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h02;
    localparam logic [7:0] ADDR_WD_CTRL = 8'h03;
    localparam logic [7:0] ADDR_WD_SVC = 8'h04;
    localparam logic [7:0] ADDR_RST_STAT = 8'h05;
    // Oscillator control fields
    localparam int OSC_EN_BIT = 7;
    localparam int OSC_WIDE_BIT = 6;
    localparam int OSC_RATIO_MSB = 4;
    // Flag register fields
    localparam int FLG_QUAL_BIT = 0;
    localparam int FLG_CHG_BIT = 1;
    localparam int FLG_LOCK_BIT = 2;
    // Clock select fields
    localparam int SEL_PLL_BIT = 0;
    localparam int SEL_WDOSC_BIT = 1;
    localparam int SEL_PSEUDO_STOP_SELECT_BIT = 2;
    localparam int SEL_PRUN_BIT = 3;
    localparam logic [3:0] CLK_SEL_RST = 4'h1;
    // Watchdog control fields
    localparam int WD_WIN_BIT = 7;
    localparam int WD_RATE_MSB = 2;
    localparam int WD_LOCK_BIT = 6;
    // Watchdog service codes
    localparam logic [7:0] WD_SVC_FIRST = 8'h55;
    localparam logic [7:0] WD_SVC_SECOND = 8'haa;
    // Watchdog period: 2^(base + 2*rate) ticks
    localparam int WD_CNT_W = 24;
    localparam logic [4:0] WD_BASE_EXP = 5'h06;
    // Reset sequence lengths in clock cycles
    localparam int DRIVE_CYCLES = 512;
    localparam int WAIT_CYCLES = 256;
    localparam int SEQ_CNT_W = 10;
    localparam logic [SEQ_CNT_W-1:0] DRIVE_LAST = SEQ_CNT_W'(DRIVE_CYCLES - 1);
    localparam logic [SEQ_CNT_W-1:0] WAIT_LAST = SEQ_CNT_W'(WAIT_CYCLES - 1);
    // Reset vector codes
    localparam logic [1:0] VEC_POR = 2'h0;
    localparam logic [1:0] VEC_CM = 2'h1;
    localparam logic [1:0] VEC_COP = 2'h2;
    // Reset sequencer states
    typedef enum logic [1:0] {SEQ_DRIVE, SEQ_WAIT, SEQ_HOLD, SEQ_RUN} cmr_seq_t;
endpackage

// ---- hdl/cmr_wdog.sv ----
// Windowed watchdog counter with service-pair checking
`timescale 1ns/1ps
`default_nettype none
module cmr_wdog
    import cmr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic [2:0] rate_i,
    input wire logic window_en_i,
    input wire logic svc_wr_i,
    input wire logic [7:0] svc_data_i,
    output logic timeout_o,
    output logic bad_svc_o
);
    logic [WD_CNT_W-1:0] cnt_q;
    logic armed_q;
    wire enabled = (rate_i != 3'h0);
    wire [4:0] exp_w = WD_BASE_EXP + {1'b0, rate_i, 1'b0};
    wire [WD_CNT_W-1:0] last_w = (WD_CNT_W'(1) << exp_w) - WD_CNT_W'(1);
    wire [WD_CNT_W-1:0] win_start_w = last_w - (last_w >> 2);
    // Service decode; a write while disabled is ignored
    wire svc_w = svc_wr_i && enabled;
    wire first_w = svc_w && (svc_data_i == WD_SVC_FIRST);
    wire second_w = svc_w && (svc_data_i == WD_SVC_SECOND);
    wire in_win_w = !window_en_i || (cnt_q >= win_start_w);
    wire early_w = (first_w || second_w) && !in_win_w;
    wire bad_code_w = svc_w && !first_w && !second_w;
    wire restart_w = second_w && armed_q && in_win_w;
    wire expire_w = enabled && tick_i && (cnt_q == last_w);

    // Counter, arming and one-cycle fault pulses
    always_ff @(posedge mclk_i) begin
        if (clr_i || restart_w || expire_w || !enabled) begin
            cnt_q <= '0;
        end else if (tick_i) begin
            cnt_q <= cnt_q + WD_CNT_W'(1);
        end
        if (clr_i || restart_w || (second_w && !armed_q)) begin
            armed_q <= 1'b0;
        end else if (first_w && in_win_w) begin
            armed_q <= 1'b1;
        end
        timeout_o <= !clr_i && expire_w;
        bad_svc_o <= !clr_i && (bad_code_w || early_w);
    end

    property p_bad_code;
        @(posedge mclk_i) disable iff (clr_i)
        (svc_wr_i && enabled && svc_data_i != WD_SVC_FIRST && svc_data_i != WD_SVC_SECOND)
        |=> bad_svc_o;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad service code not flagged");
    property p_restart;
        @(posedge mclk_i) disable iff (clr_i)
        (svc_wr_i && svc_data_i == WD_SVC_SECOND && armed_q && enabled && in_win_w)
        |=> (cnt_q == '0) && !armed_q;
    endproperty
    a_restart: assert property (p_restart) else $error("service pair did not restart");
endmodule
`default_nettype wire

// ---- hdl/cmr_top.sv ----
// Clock mode control, reset generator and watchdog front end
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cmr_top
    import cmr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [cmr_pkg::AW-1:0] addr_i,
    input wire logic [cmr_pkg::DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [cmr_pkg::DW-1:0] rdata_o,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    input wire logic pll_lock_i,
    input wire logic osc_qual_raw_i,
    input wire logic osc_clk_ok_i,
    input wire logic osc_disturb_i,
    input wire logic chip_reset_req_i,
    input wire logic stop_i,
    input wire logic special_mode_i,
    input wire logic rc_tick_i,
    input wire logic osc_tick_i,
    output logic sys_reset_o,
    output logic [1:0] vector_o,
    output logic osc_enable_o,
    output logic bus_clk_from_pll_o,
    output logic pll_ref_osc_o,
    output logic pll_div4_o,
    output logic vco_reset_freq_o,
    output logic osc_clk_pause_o,
    output logic wdog_clk_osc_o
);
    import cmr_pkg::*;

    // Pin and analog inputs: lock, qualify, clock ok, disturb, reset pin
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    always_ff @(posedge mclk_i) begin
        sync1_q <= {pll_lock_i, osc_qual_raw_i, osc_clk_ok_i, osc_disturb_i, reset_pin_i};
        sync2_q <= sync1_q;
    end
    wire lock_s = sync2_q[4];
    wire qual_raw_s = sync2_q[3];
    wire clk_ok_s = sync2_q[2];
    wire disturb_s = sync2_q[1];
    wire pin_s = sync2_q[0];

    // Control and status state
    logic osc_en_q;
    logic osc_wide_q;
    logic [4:0] osc_ratio_q;
    logic [3:0] clk_sel_q;
    logic wd_win_q;
    logic [2:0] wd_rate_q;
    logic wd_lock_q;
    logic qual_q;
    logic chg_q;
    logic cm_pend_q;
    logic cop_pend_q;
    logic [DW-1:0] rdata_q;
    cmr_seq_t state_q;
    cmr_seq_t state_d;
    logic [SEQ_CNT_W-1:0] cnt_q;
    logic [SEQ_CNT_W-1:0] cnt_d;
    logic wd_timeout;
    logic wd_bad;

    // Register decode
    wire wr_osc = wr_i && (addr_i == ADDR_OSC_CTRL);
    wire wr_flag = wr_i && (addr_i == ADDR_FLAG);
    wire wr_sel = wr_i && (addr_i == ADDR_CLK_SEL);
    wire wr_wdc = wr_i && (addr_i == ADDR_WD_CTRL);
    wire wr_svc = wr_i && (addr_i == ADDR_WD_SVC);
    wire pll_sel = clk_sel_q[SEL_PLL_BIT];
    wire wd_osc = clk_sel_q[SEL_WDOSC_BIT];
    wire pseudo_stop_select = clk_sel_q[SEL_PSEUDO_STOP_SELECT_BIT];
    wire prun = clk_sel_q[SEL_PRUN_BIT];
    // Full Stop is Stop without pseudo stop; the oscillator is powered down then
    wire full_stop = stop_i && !pseudo_stop_select;
    wire osc_on = osc_en_q && !full_stop;
    // Qualification needs lock: the filter runs from the VCO clock
    wire qual_d = osc_on && lock_s && qual_raw_s;
    wire qual_fell = qual_q && !qual_d;
    wire cm_fail = osc_on && !clk_ok_s;
    // Control write is allowed until locked, always in special mode
    wire wdc_take = wr_wdc && (!wd_lock_q || special_mode_i);

    // Read data multiplexer; unmapped addresses read zero
    logic [DW-1:0] rmux;
    always_comb begin
        rmux = '0;
        case (addr_i)
            ADDR_OSC_CTRL: rmux = {osc_en_q, osc_wide_q, 1'b0, osc_ratio_q};
            ADDR_FLAG: rmux = {5'h00, lock_s, chg_q, qual_q};
            ADDR_CLK_SEL: rmux = {4'h0, clk_sel_q};
            ADDR_WD_CTRL: rmux = {wd_win_q, wd_lock_q, 3'h0, wd_rate_q};
            ADDR_RST_STAT: rmux = {4'h0, cop_pend_q, cm_pend_q, vector_o};
            default: rmux = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !rd_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rmux;
        end
    end
    assign rdata_o = rdata_q;

    // Reset sequencer: request, pin drive, wait, sample, hold
    wire sample = (state_q == SEQ_WAIT) && (cnt_q == WAIT_LAST);
    wire reset_req = chip_reset_req_i || !pin_s || cm_pend_q || cop_pend_q;
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + SEQ_CNT_W'(1);
        case (state_q)
            SEQ_RUN: begin
                cnt_d = '0;
                if (reset_req) begin
                    state_d = SEQ_DRIVE;
                end
            end
            SEQ_DRIVE: begin
                if (cnt_q == DRIVE_LAST) begin
                    state_d = SEQ_WAIT;
                    cnt_d = '0;
                end
            end
            SEQ_WAIT: begin
                if (sample) begin
                    state_d = pin_s ? SEQ_RUN : SEQ_HOLD;
                    cnt_d = '0;
                end
            end
            SEQ_HOLD: begin
                cnt_d = '0;
                if (pin_s) begin
                    state_d = SEQ_RUN;
                end
            end
            default: begin
                state_d = SEQ_DRIVE;
                cnt_d = '0;
            end
        endcase
    end

    // Sequencer registers and reset-time outputs; power-up starts a full sequence
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            state_q <= SEQ_DRIVE;
            cnt_q <= '0;
            reset_pin_oe_o <= 1'b1;
            sys_reset_o <= 1'b1;
            vco_reset_freq_o <= 1'b1;
            vector_o <= VEC_POR;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            reset_pin_oe_o <= (state_d == SEQ_DRIVE);
            sys_reset_o <= (state_d != SEQ_RUN);
            vco_reset_freq_o <= (state_d != SEQ_RUN);
            if (sample) begin
                if (pin_s && cm_pend_q) begin
                    vector_o <= VEC_CM;
                end else if (pin_s && cop_pend_q) begin
                    vector_o <= VEC_COP;
                end else begin
                    vector_o <= VEC_POR;
                end
            end
        end
    end
    // Pin is only ever pulled low; the enable does the work
    always_ff @(posedge mclk_i) begin
        reset_pin_o <= 1'b0;
    end

    // Pending failures: cleared once the vector is chosen, a new event wins
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cm_pend_q <= 1'b0;
            cop_pend_q <= 1'b0;
        end else begin
            cm_pend_q <= cm_fail || (cm_pend_q && !sample);
            cop_pend_q <= wd_timeout || wd_bad || (cop_pend_q && !sample);
        end
    end

    // Control registers return to defaults on every system reset
    wire ctl_rst = !resetn_i || sys_reset_o;
    always_ff @(posedge mclk_i) begin
        if (ctl_rst) begin
            osc_en_q <= 1'b0;
            osc_wide_q <= 1'b0;
            osc_ratio_q <= '0;
            clk_sel_q <= CLK_SEL_RST;
            wd_win_q <= 1'b0;
            wd_rate_q <= '0;
            wd_lock_q <= 1'b0;
        end else begin
            if (wr_osc) begin
                osc_en_q <= wdata_i[OSC_EN_BIT];
                osc_wide_q <= wdata_i[OSC_WIDE_BIT];
                osc_ratio_q <= wdata_i[OSC_RATIO_MSB:0];
            end
            if (wr_sel) begin
                clk_sel_q <= wdata_i[SEL_PRUN_BIT:0];
            end
            // Hardware fallback to the PLL wins over a software write
            if (qual_fell && !pll_sel) begin
                clk_sel_q[SEL_PLL_BIT] <= 1'b1;
            end
            if (wdc_take) begin
                wd_win_q <= wdata_i[WD_WIN_BIT];
                wd_rate_q <= wdata_i[WD_RATE_MSB:0];
                wd_lock_q <= !special_mode_i;
            end
        end
    end

    // Oscillator status flag and its sticky change flag; a change beats the clear
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            qual_q <= 1'b0;
            chg_q <= 1'b0;
        end else begin
            qual_q <= qual_d;
            if (qual_d != qual_q) begin
                chg_q <= 1'b1;
            end else if (wr_flag && wdata_i[FLG_CHG_BIT]) begin
                chg_q <= 1'b0;
            end
        end
    end

    // Clock steering outputs
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            osc_enable_o <= 1'b0;
            bus_clk_from_pll_o <= 1'b1;
            pll_ref_osc_o <= 1'b0;
            pll_div4_o <= 1'b1;
            osc_clk_pause_o <= 1'b0;
            wdog_clk_osc_o <= 1'b0;
        end else begin
            osc_enable_o <= osc_on;
            bus_clk_from_pll_o <= pll_sel;
            pll_ref_osc_o <= osc_on;
            pll_div4_o <= !lock_s;
            // Status bits miss such disturbances, so the clock is held until stable
            osc_clk_pause_o <= !pll_sel && lock_s && qual_q && disturb_s;
            wdog_clk_osc_o <= wd_osc;
        end
    end

    // Watchdog tick: clock select, halted in Stop except in pseudo stop with the oscillator source selected and prun set
    wire wd_src = wd_osc ? osc_tick_i : rc_tick_i;
    wire wd_run = !stop_i || (pseudo_stop_select && wd_osc && prun);
    cmr_wdog u_wdog (
        .mclk_i(mclk_i),
        .clr_i(ctl_rst || sample),
        .tick_i(wd_src && wd_run),
        .rate_i(wd_rate_q),
        .window_en_i(wd_win_q),
        .svc_wr_i(wr_svc),
        .svc_data_i(wdata_i),
        .timeout_o(wd_timeout),
        .bad_svc_o(wd_bad)
    );

    property p_drive_len;
        @(posedge mclk_i) disable iff (!resetn_i)
        $fell(reset_pin_oe_o) |-> $past(cnt_q) == DRIVE_LAST;
    endproperty
    a_drive_len: assert property (p_drive_len) else $error("pin drive length wrong");
    property p_sample_at;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state_q == SEQ_WAIT && cnt_q == WAIT_LAST && pin_s) |=> !sys_reset_o;
    endproperty
    a_sample_at: assert property (p_sample_at) else $error("no release at sample");
    property p_cm_vec;
        @(posedge mclk_i) disable iff (!resetn_i)
        (sample && pin_s && cm_pend_q) |=> vector_o == VEC_CM;
    endproperty
    a_cm_vec: assert property (p_cm_vec) else $error("clock monitor vector missed");
    property p_hold;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state_q != SEQ_RUN) |-> sys_reset_o && vco_reset_freq_o;
    endproperty
    a_hold: assert property (p_hold) else $error("internal reset dropped early");
    property p_unlock_qual;
        @(posedge mclk_i) disable iff (!resetn_i)
        !lock_s |=> !qual_q && pll_div4_o;
    endproperty
    a_unlock_qual: assert property (p_unlock_qual) else $error("qualified kept without lock");
    property p_chg;
        @(posedge mclk_i) disable iff (!resetn_i)
        (qual_d != qual_q) |=> chg_q;
    endproperty
    a_chg: assert property (p_chg) else $error("status change not flagged");
    property p_fallback;
        @(posedge mclk_i) disable iff (ctl_rst)
        (qual_fell && !pll_sel) |=> pll_sel ##1 bus_clk_from_pll_o;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to PLL clock");
    property p_wd_lock;
        @(posedge mclk_i) disable iff (ctl_rst)
        (wr_wdc && wd_lock_q && !special_mode_i) |=> $stable(wd_rate_q) && $stable(wd_win_q);
    endproperty
    a_wd_lock: assert property (p_wd_lock) else $error("locked watchdog bits changed");
endmodule
`default_nettype wire

// ---- verification/cmr_partner.sv ----
// Model of the board reset line and the external oscillator with its PLL status
`timescale 1ns/1ps
`default_nettype none
module cmr_partner (
    input wire logic mclk_i,
    input wire logic pin_drive_i,
    input wire logic pin_oe_i,
    input wire logic ext_low_i,
    input wire logic lock_want_i,
    input wire logic qual_want_i,
    input wire logic clk_ok_i,
    input wire logic disturb_i,
    output logic reset_pin_o,
    output logic pll_lock_o,
    output logic osc_qual_o,
    output logic osc_ok_o,
    output logic disturb_o,
    output logic rc_tick_o,
    output logic osc_tick_o
);
    logic [4:0] lock_cnt_q = 5'h00;
    logic [1:0] tick_cnt_q = 2'h0;
    // Pulled-up line: low while the device drives it or the board holds it
    assign reset_pin_o = !((pin_oe_i && !pin_drive_i) || ext_low_i);
    // Lock comes slowly, loss is immediate; qualification needs lock
    always_ff @(posedge mclk_i) begin
        lock_cnt_q <= !lock_want_i ? 5'h00 : (lock_cnt_q == 5'h10 ? lock_cnt_q : lock_cnt_q + 5'h01);
        tick_cnt_q <= tick_cnt_q + 2'h1;
    end
    assign pll_lock_o = (lock_cnt_q == 5'h10);
    assign osc_qual_o = pll_lock_o && qual_want_i;
    assign osc_ok_o = clk_ok_i;
    assign disturb_o = disturb_i;
    // Watchdog ticks: RC every other cycle, oscillator every fourth
    assign rc_tick_o = tick_cnt_q[0];
    assign osc_tick_o = (tick_cnt_q == 2'h3);
endmodule
`default_nettype wire

// ---- verification/test_cmr_top.sv ----
// Self-checking bench for the clock mode, reset generator and watchdog block
`timescale 1ns/1ps
`default_nettype none
module test_cmr_top;
    import cmr_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic chip_reset_req_i = 1'b0;
    logic stop_i = 1'b0;
    logic ext_low = 1'b0;
    logic lock_want = 1'b0;
    logic qual_want = 1'b0;
    logic clk_ok = 1'b1;
    logic disturb = 1'b0;
    logic special_mode = 1'b0;
    wire logic [7:0] rdata_o;
    wire logic reset_pin_i, reset_pin_o, reset_pin_oe_o, pll_lock_i, osc_qual_raw_i;
    wire logic osc_clk_ok_i, osc_disturb_i, rc_tick_i, osc_tick_i, sys_reset_o;
    wire logic [1:0] vector_o;
    wire logic osc_enable_o, bus_clk_from_pll_o, pll_ref_osc_o, pll_div4_o;
    wire logic vco_reset_freq_o, osc_clk_pause_o, wdog_clk_osc_o;
    int failures = 0;
    int samples_checked = 0;

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    cmr_top DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reset_pin_i(reset_pin_i),
        .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .pll_lock_i(pll_lock_i),
        .osc_qual_raw_i(osc_qual_raw_i), .osc_clk_ok_i(osc_clk_ok_i),
        .osc_disturb_i(osc_disturb_i), .chip_reset_req_i(chip_reset_req_i), .stop_i(stop_i),
        .special_mode_i(special_mode), .rc_tick_i(rc_tick_i), .osc_tick_i(osc_tick_i),
        .sys_reset_o(sys_reset_o), .vector_o(vector_o), .osc_enable_o(osc_enable_o),
        .bus_clk_from_pll_o(bus_clk_from_pll_o), .pll_ref_osc_o(pll_ref_osc_o),
        .pll_div4_o(pll_div4_o), .vco_reset_freq_o(vco_reset_freq_o),
        .osc_clk_pause_o(osc_clk_pause_o), .wdog_clk_osc_o(wdog_clk_osc_o));

    cmr_partner far_side (.mclk_i(mclk_i), .pin_drive_i(reset_pin_o), .pin_oe_i(reset_pin_oe_o),
        .ext_low_i(ext_low), .lock_want_i(lock_want), .qual_want_i(qual_want),
        .clk_ok_i(clk_ok), .disturb_i(disturb), .reset_pin_o(reset_pin_i),
        .pll_lock_o(pll_lock_i), .osc_qual_o(osc_qual_raw_i), .osc_ok_o(osc_clk_ok_i),
        .disturb_o(osc_disturb_i), .rc_tick_o(rc_tick_i), .osc_tick_o(osc_tick_i));

    task automatic finish_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A used-up wait bound ends the run as a failure
    task automatic guard(input int n);
        if (n >= 3000) begin
            failures++;
            finish_test();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Follow one reset sequence; exact timing checked only when the start is clean
    task automatic seq(input logic [1:0] ev, input bit exact);
        int n;
        int m;
        n = 0;
        m = 0;
        while (reset_pin_oe_o !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        guard(n);
        chk(vco_reset_freq_o, 1'b1);
        n = 0;
        while (reset_pin_oe_o === 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        guard(n);
        if (exact) begin
            chk(n, 512);
        end
        while (sys_reset_o === 1'b1 && m < 3000) begin
            cyc(1);
            m++;
        end
        guard(m);
        // The sample edge also releases the internal reset, so the wait is exact
        if (exact) begin
            chk(m, 256);
        end
        chk(vector_o, ev);
        cyc(2);
    endtask

    task automatic service();
        wr(ADDR_WD_SVC, WD_SVC_FIRST);
        wr(ADDR_WD_SVC, WD_SVC_SECOND);
    endtask

    initial begin
        // Reset is low over three rising edges, released by the third
        cyc(2);
        chk({reset_pin_oe_o, sys_reset_o}, 2'h3);
        @(posedge mclk_i);
        resetn_i <= 1'b1;
        seq(VEC_POR, 1'b0);
        rd(ADDR_CLK_SEL, {4'h0, CLK_SEL_RST});
        rd(ADDR_RST_STAT, {6'h00, VEC_POR});
        // Engaged external mode entry, in the software order
        wr(ADDR_OSC_CTRL, 8'h80);
        lock_want <= 1'b1;
        qual_want <= 1'b1;
        cyc(30);
        chk({osc_enable_o, pll_ref_osc_o, bus_clk_from_pll_o, pll_div4_o}, 4'he);
        rd(ADDR_FLAG, 8'h07);
        wr(ADDR_FLAG, 8'h02);
        rd(ADDR_FLAG, 8'h05);
        lock_want <= 1'b0;
        cyc(6);
        chk(pll_div4_o, 1'b1);
        rd(ADDR_FLAG, 8'h02);
        lock_want <= 1'b1;
        cyc(30);
        wr(ADDR_FLAG, 8'h02);
        // Bypassed mode: select is cleared last
        wr(ADDR_CLK_SEL, 8'h02);
        cyc(4);
        chk({bus_clk_from_pll_o, wdog_clk_osc_o}, 2'h1);
        disturb <= 1'b1;
        cyc(6);
        chk(osc_clk_pause_o, 1'b1);
        disturb <= 1'b0;
        qual_want <= 1'b0;
        cyc(6);
        chk(bus_clk_from_pll_o, 1'b1);
        rd(ADDR_CLK_SEL, 8'h03);
        clk_ok <= 1'b0;
        seq(VEC_CM, 1'b0);
        clk_ok <= 1'b1;
        // Clean request over exactly one edge: exact drive and wait lengths
        @(posedge mclk_i);
        chip_reset_req_i <= 1'b1;
        @(posedge mclk_i);
        chip_reset_req_i <= 1'b0;
        #1;
        seq(VEC_POR, 1'b1);
        // Board holds the pin beyond the full sequence; no new drive follows release
        ext_low <= 1'b1;
        cyc(1000);
        chk(sys_reset_o, 1'b1);
        ext_low <= 1'b0;
        // Two synchroniser edges, then the hold ends at the third
        cyc(4);
        chk(sys_reset_o, 1'b0);
        chk(vco_reset_freq_o, 1'b0);
        chk(vector_o, VEC_POR);
        // First control write locks rate and window
        wr(ADDR_WD_CTRL, 8'h01);
        wr(ADDR_WD_CTRL, 8'h83);
        rd(ADDR_WD_CTRL, 8'h41);
        repeat (4) begin
            cyc(300);
            service();
        end
        chk(sys_reset_o, 1'b0);
        // Full Stop halts the counter and the oscillator
        wr(ADDR_OSC_CTRL, 8'h80);
        stop_i <= 1'b1;
        cyc(1200);
        chk({sys_reset_o, osc_enable_o}, 2'h0);
        @(posedge mclk_i);
        stop_i <= 1'b0;
        seq(VEC_COP, 1'b0);
        wr(ADDR_WD_CTRL, 8'h01);
        wr(ADDR_WD_SVC, 8'h12);
        seq(VEC_COP, 1'b0);
        rd(ADDR_RST_STAT, {6'h00, VEC_COP});
        // Window mode: late service passes, early one resets
        wr(ADDR_WD_CTRL, 8'h81);
        cyc(440);
        service();
        cyc(10);
        chk(sys_reset_o, 1'b0);
        wr(ADDR_WD_SVC, WD_SVC_FIRST);
        seq(VEC_COP, 1'b0);
        // Special mode keeps the watchdog control bits writable
        @(posedge mclk_i);
        special_mode <= 1'b1;
        wr(ADDR_WD_CTRL, 8'h01);
        wr(ADDR_WD_CTRL, 8'h82);
        rd(ADDR_WD_CTRL, 8'h82);
        finish_test();
    end
endmodule
`default_nettype wire
